// >>> design/tmr_pkg.sv
// Shared constants, types and register map of the 8-bit timer
package tmr_pkg;
	// Register byte offsets on the bus (one aligned word each)
	localparam logic [4:0] OFS_CTRL_A = 5'h00;
	localparam logic [4:0] OFS_CTRL_B = 5'h04;
	localparam logic [4:0] OFS_COUNT  = 5'h08;
	localparam logic [4:0] OFS_CMP    = 5'h0c;
	localparam logic [4:0] OFS_FLAG   = 5'h10;
	localparam logic [4:0] OFS_MASK   = 5'h14;
	localparam logic [4:0] OFS_ASYNC  = 5'h18;
	localparam logic [4:0] OFS_PORT   = 5'h1c;
	// Field positions
	localparam int CA_MODE_LSB  = 0;
	localparam int CA_COM_LSB   = 4;
	localparam int CA_FORCE_BIT = 7;
	localparam int CB_CS_LSB    = 0;
	localparam int FLG_OVF_BIT  = 0;
	localparam int FLG_CMP_BIT  = 1;
	localparam int AS_CLK_BIT   = 0;
	localparam int PT_DATA_BIT  = 0;
	localparam int PT_DIR_BIT   = 1;
	// Count extremes and reset values
	localparam logic [7:0] CNT_BOTTOM = 8'h00;
	localparam logic [7:0] CNT_MAX    = 8'hff;
	localparam logic [7:0] RST_BYTE   = 8'h00;
	localparam logic [2:0] CS_STOP    = 3'h0;
	localparam logic [1:0] COM_OFF    = 2'h0;
	localparam logic [1:0] COM_TOGGLE = 2'h1;
	localparam logic [1:0] COM_CLEAR  = 2'h2;
	localparam logic [1:0] COM_SET    = 2'h3;
	localparam int PRE_W = 10;
	// Waveform modes
	typedef enum logic [1:0] {
		TMR_NORMAL = 2'h0,
		TMR_PC_PWM = 2'h1,
		TMR_CTC    = 2'h2,
		TMR_FAST   = 2'h3
	} tmr_mode_t;
	// Classic Wishbone request and answer
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [3:0]  sel;
		logic [4:0]  adr;
		logic [31:0] dat;
	} tmr_wb_req_t;
	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
	} tmr_wb_rsp_t;
endpackage : tmr_pkg

// >>> design/tmr_prescale.sv
// Clock select and prescaler producing the one-cycle timer tick
`timescale 1ns/10ps
`default_nettype none
module tmr_prescale #(
	parameter int PRE_W = tmr_pkg::PRE_W
) (
	input  wire logic       clk_sys,
	input  wire logic       rst,
	input  wire logic       use_xtal,
	input  wire logic       xtal_lvl,
	input  wire logic [2:0] clk_sel,
	output var  logic       tick
);
	logic             xtal_d_r;
	logic             src_tick;
	logic [PRE_W-1:0] pre_r;

	// Tap hit for each divisor: 1, 8, 32, 64, 128, 256, 1024
	function automatic logic tap_hit(input logic [PRE_W-1:0] c, input logic [2:0] s);
		logic [PRE_W-1:0] m;
		m = '0;
		unique case (s)
			3'h1: m = '0;
			3'h2: m = PRE_W'(10'h007);
			3'h3: m = PRE_W'(10'h01f);
			3'h4: m = PRE_W'(10'h03f);
			3'h5: m = PRE_W'(10'h07f);
			3'h6: m = PRE_W'(10'h0ff);
			3'h7: m = PRE_W'(10'h3ff);
			default: m = '0;
		endcase
		return (c & m) == m;
	endfunction : tap_hit

	// The crystal edge is taken from the synchronised level only
	assign src_tick = use_xtal ? (xtal_lvl & ~xtal_d_r) : 1'b1;

	// Prescaler counts source edges; a stopped select gives no tick
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			xtal_d_r <= 1'b0;
			pre_r    <= '0;
			tick     <= 1'b0;
		end else begin
			xtal_d_r <= xtal_lvl;
			if (src_tick) begin
				pre_r <= PRE_W'(pre_r + 1'b1);
			end
			tick <= src_tick && (clk_sel != tmr_pkg::CS_STOP) && tap_hit(pre_r, clk_sel); // [R2]
		end
	end
endmodule : tmr_prescale
`default_nettype wire

// >>> design/tmr_sync.sv
// Two-flop synchroniser for a level from outside the clock domain
`timescale 1ns/10ps
`default_nettype none
module tmr_sync (
	input  wire logic clk_sys,
	input  wire logic rst,
	input  wire logic async_in,
	output var  logic sync_out
);
	logic meta_r;

	// First stage feeds only the second stage
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			meta_r   <= 1'b0;
			sync_out <= 1'b0;
		end else begin
			meta_r   <= async_in;
			sync_out <= meta_r;
		end
	end
endmodule : tmr_sync
`default_nettype wire

// >>> design/tmr_top.sv
// What this block does
// [R1] Counter and compare value are 8 bits
// [R2] Clock select zero stops the counter
// [R3] Async select switches source to crystal
// [R4] Each tick clears, increments or decrements
// [R5] CPU counter write beats count or clear
// [R6] Counter readable and writable when stopped
// [R7] Mode bits pick sequence and overflow rule
// [R8] Equality sets compare flag next tick
// [R9] Enabled flag requests interrupt; ack clears
// [R10] Compare double buffered in PWM modes
// [R11] CPU reaches buffer in PWM, else direct
// [R12] Force strobe acts on output, no flag
// [R13] Counter write blocks next tick's match
// [R14] Writing counter equal compare misses match
// [R15] Output state survives mode changes
// [R16] Output mode changes act immediately
// [R17] Bottom 0x00, max 0xff, top per mode
// [R18] Requests shown in flags, masked individually
// [R19] Software sets output before pin direction
// [R20] Normal mode wraps up, overflow at zero
// [R21] CTC mode clears counter on match
// [R22] Fast PWM single slope, set/clear output
// [R23] Mode zero no action; nonzero overrides port
// [R24] Phase-correct PWM counts up then down
`timescale 1ns/10ps
`default_nettype none
module tmr_top (
	input  wire logic                clk_sys,
	input  wire logic                rst,
	input  wire tmr_pkg::tmr_wb_req_t wb_req,
	output tmr_pkg::tmr_wb_rsp_t     wb_rsp,
	input  wire logic                crystal_pin_in,
	input  wire logic                irq_ack_ovf,
	input  wire logic                irq_ack_cmp,
	output logic                     irq_ovf,
	output logic                     irq_cmp,
	output logic                     compare_output_o,
	output logic                     compare_output_oe
);
	logic [1:0] mode_r;
	logic [1:0] com_r;
	logic [2:0] cs_r;
	logic       xsel_r;
	logic       ovf_en_r;
	logic       cmp_en_r;
	logic       port_dat_r;
	logic       port_dir_r;
	logic [7:0] cnt_r;
	logic [7:0] cnt_nxt;
	logic       dir_r;
	logic       dir_nxt;
	logic [7:0] ocr_r;
	logic [7:0] obuf_r;
	logic       block_r;
	logic       ovf_flg_r;
	logic       cmp_flg_r;
	logic       wave_r;
	logic       xtal_lvl;
	logic       tick;
	logic       acc;
	logic       wr;
	logic       wr_ca;
	logic       cnt_wr;
	logic       cmp_wr;
	logic       flg_wr;
	logic [7:0] wdat;
	logic       pwm;
	logic       eq;
	logic       match_evt;
	logic       top_evt;
	logic       ovf_evt;
	logic       force_evt;
	logic [7:0] rd_byte;

	// Non-PWM modes are normal and CTC
	function automatic logic is_pwm(input logic [1:0] m);
		return (m == tmr_pkg::TMR_PC_PWM) || (m == tmr_pkg::TMR_FAST);
	endfunction : is_pwm

	tmr_sync u_sync (
		.clk_sys  (clk_sys),
		.rst      (rst),
		.async_in (crystal_pin_in),
		.sync_out (xtal_lvl)
	);

	tmr_prescale u_pre (
		.clk_sys  (clk_sys),
		.rst      (rst),
		.use_xtal (xsel_r), // [R3]
		.xtal_lvl (xtal_lvl),
		.clk_sel  (cs_r),
		.tick     (tick)
	);

	// Bus decode; a write lands only at the edge where the master samples ack
	assign acc    = wb_req.cyc & wb_req.stb & ~wb_rsp.ack;
	assign wr     = wb_req.cyc & wb_req.stb & wb_rsp.ack & wb_req.we & wb_req.sel[0];
	assign wdat   = wb_req.dat[7:0];
	assign wr_ca  = wr && (wb_req.adr == tmr_pkg::OFS_CTRL_A);
	assign cnt_wr = wr && (wb_req.adr == tmr_pkg::OFS_COUNT);
	assign cmp_wr = wr && (wb_req.adr == tmr_pkg::OFS_CMP);
	assign flg_wr = wr && (wb_req.adr == tmr_pkg::OFS_FLAG);

	// Comparator runs every cycle; match and top events only on a tick
	assign pwm       = is_pwm(mode_r);
	assign eq        = (cnt_r == ocr_r); // [R8]
	assign match_evt = tick & eq & ~block_r & ~cnt_wr; // [R13] [R14]
	assign top_evt   = tick & ~cnt_wr & (cnt_r == tmr_pkg::CNT_MAX) & ~dir_r; // [R17]
	assign force_evt = wr_ca & wdat[tmr_pkg::CA_FORCE_BIT] & ~is_pwm(wdat[1:0]); // [R12]

	// Overflow condition depends on the mode
	always_comb begin
		ovf_evt = 1'b0;
		if (tick && !cnt_wr) begin
			if (mode_r == tmr_pkg::TMR_PC_PWM) begin
				ovf_evt = dir_r && (cnt_r == tmr_pkg::CNT_BOTTOM); // [R7]
			end else begin
				ovf_evt = (cnt_r == tmr_pkg::CNT_MAX); // [R20]
			end
		end
	end

	// Counter sequence; a CPU write wins over any count
	always_comb begin
		cnt_nxt = cnt_r;
		dir_nxt = dir_r;
		if (cnt_wr) begin
			cnt_nxt = wdat; // [R5] [R6]
		end else if (tick) begin // [R4]
			unique case (mode_r)
				tmr_pkg::TMR_CTC: begin
					cnt_nxt = match_evt ? tmr_pkg::CNT_BOTTOM : 8'(cnt_r + 8'h01); // [R21]
				end
				tmr_pkg::TMR_PC_PWM: begin
					if (!dir_r) begin
						if (cnt_r == tmr_pkg::CNT_MAX) begin
							dir_nxt = 1'b1; // [R24]
							cnt_nxt = 8'(cnt_r - 8'h01);
						end else begin
							cnt_nxt = 8'(cnt_r + 8'h01);
						end
					end else if (cnt_r == tmr_pkg::CNT_BOTTOM) begin
						dir_nxt = 1'b0;
						cnt_nxt = 8'(cnt_r + 8'h01);
					end else begin
						cnt_nxt = 8'(cnt_r - 8'h01); // [R24]
					end
				end
				default: begin
					cnt_nxt = 8'(cnt_r + 8'h01); // [R20] [R22]
				end
			endcase
		end
		if (mode_r != tmr_pkg::TMR_PC_PWM) begin
			dir_nxt = 1'b0;
		end
	end

	// Counter, direction and match blocking
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			cnt_r   <= tmr_pkg::RST_BYTE;
			dir_r   <= 1'b0;
			block_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt; // [R1]
			dir_r <= dir_nxt;
			// Held even while stopped, so it blocks the first tick
			if (cnt_wr) begin
				block_r <= 1'b1; // [R13]
			end else if (tick) begin
				block_r <= 1'b0;
			end
		end
	end

	// Control registers written by software
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			mode_r     <= tmr_pkg::TMR_NORMAL;
			com_r      <= tmr_pkg::COM_OFF;
			cs_r       <= tmr_pkg::CS_STOP;
			xsel_r     <= 1'b0;
			ovf_en_r   <= 1'b0;
			cmp_en_r   <= 1'b0;
			port_dat_r <= 1'b0;
			port_dir_r <= 1'b0;
		end else if (wr) begin
			unique case (wb_req.adr)
				tmr_pkg::OFS_CTRL_A: begin
					mode_r <= wdat[tmr_pkg::CA_MODE_LSB +: 2]; // [R7]
					com_r  <= wdat[tmr_pkg::CA_COM_LSB +: 2]; // [R16]
				end
				tmr_pkg::OFS_CTRL_B: cs_r <= wdat[tmr_pkg::CB_CS_LSB +: 3];
				tmr_pkg::OFS_ASYNC: xsel_r <= wdat[tmr_pkg::AS_CLK_BIT]; // [R3]
				tmr_pkg::OFS_MASK: begin
					ovf_en_r <= wdat[tmr_pkg::FLG_OVF_BIT]; // [R18]
					cmp_en_r <= wdat[tmr_pkg::FLG_CMP_BIT];
				end
				tmr_pkg::OFS_PORT: begin
					port_dat_r <= wdat[tmr_pkg::PT_DATA_BIT];
					port_dir_r <= wdat[tmr_pkg::PT_DIR_BIT];
				end
				default: ;
			endcase
		end
	end

	// Compare value and its buffer; PWM loads at top only
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ocr_r  <= tmr_pkg::RST_BYTE;
			obuf_r <= tmr_pkg::RST_BYTE;
		end else begin
			if (cmp_wr) begin
				obuf_r <= wdat; // [R11]
			end
			if (!pwm) begin
				if (cmp_wr) begin
					ocr_r <= wdat; // [R10] [R11]
				end
			end else if (top_evt) begin
				ocr_r <= obuf_r; // [R10]
			end
		end
	end

	// Sticky flags: a set in the clear cycle still lands
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ovf_flg_r <= 1'b0;
			cmp_flg_r <= 1'b0;
		end else begin
			if (ovf_evt) begin
				ovf_flg_r <= 1'b1; // [R20]
			end else if (irq_ack_ovf || (flg_wr && wdat[tmr_pkg::FLG_OVF_BIT])) begin
				ovf_flg_r <= 1'b0; // [R9]
			end
			if (match_evt) begin
				cmp_flg_r <= 1'b1; // [R8]
			end else if (irq_ack_cmp || (flg_wr && wdat[tmr_pkg::FLG_CMP_BIT])) begin
				cmp_flg_r <= 1'b0; // [R9]
			end
		end
	end

	// Interrupt requests, each gated by its mask bit
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			irq_ovf <= 1'b0;
			irq_cmp <= 1'b0;
		end else begin
			irq_ovf <= ovf_flg_r & ovf_en_r; // [R18]
			irq_cmp <= cmp_flg_r & cmp_en_r; // [R9] [R18]
		end
	end

	// Waveform state; never reset by a mode change
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			wave_r <= 1'b0;
		end else if (!pwm) begin
			if (match_evt || force_evt) begin // [R12]
				// A strobe uses the output mode written with it, which acts at once
				unique case (force_evt ? wdat[tmr_pkg::CA_COM_LSB +: 2] : com_r) // [R16]
					tmr_pkg::COM_TOGGLE: wave_r <= ~wave_r;
					tmr_pkg::COM_CLEAR: wave_r <= 1'b0;
					tmr_pkg::COM_SET: wave_r <= 1'b1;
					default: ; // [R23]
				endcase
			end
		end else if (mode_r == tmr_pkg::TMR_FAST) begin
			// Bottom wins at max so a full compare gives a steady level
			if (top_evt && com_r[1]) begin
				wave_r <= ~com_r[0]; // [R22]
			end else if (match_evt && com_r[1]) begin
				wave_r <= com_r[0]; // [R22]
			end
		end else if (match_evt && com_r[1]) begin
			wave_r <= com_r[0] ^ dir_r; // [R24]
		end
	end // [R15]

	// Pin: mode bits override the port data; direction stays with software
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			compare_output_o  <= 1'b0;
			compare_output_oe <= 1'b0;
		end else begin
			compare_output_o  <= (com_r != tmr_pkg::COM_OFF) ? wave_r : port_dat_r; // [R23]
			compare_output_oe <= port_dir_r; // [R19]
		end
	end

	// Read mux; force strobe reads as zero
	always_comb begin
		rd_byte = 8'h00;
		unique case (wb_req.adr)
			tmr_pkg::OFS_CTRL_A: rd_byte = {2'h0, com_r, 2'h0, mode_r};
			tmr_pkg::OFS_CTRL_B: rd_byte = {5'h00, cs_r};
			tmr_pkg::OFS_COUNT: rd_byte = cnt_r; // [R6]
			tmr_pkg::OFS_CMP: rd_byte = pwm ? obuf_r : ocr_r; // [R11]
			tmr_pkg::OFS_FLAG: rd_byte = {6'h00, cmp_flg_r, ovf_flg_r}; // [R18]
			tmr_pkg::OFS_MASK: rd_byte = {6'h00, cmp_en_r, ovf_en_r};
			tmr_pkg::OFS_ASYNC: rd_byte = {7'h00, xsel_r};
			tmr_pkg::OFS_PORT: rd_byte = {6'h00, port_dir_r, port_dat_r};
			default: rd_byte = 8'h00;
		endcase
	end

	// Bus answer: ack one cycle after the request, then dropped
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			wb_rsp <= '0;
		end else begin
			wb_rsp.ack <= acc;
			wb_rsp.dat <= acc ? {24'h000000, rd_byte} : 32'h00000000;
		end
	end

	a_stop_no_count: assert property (@(posedge clk_sys) disable iff (rst) // [R2]
		(cs_r == tmr_pkg::CS_STOP) ##1 (cs_r == tmr_pkg::CS_STOP) |-> !tick)
		else $error("tick while clock select is zero");
	a_write_wins: assert property (@(posedge clk_sys) disable iff (rst) // [R5]
		cnt_wr |=> (cnt_r == $past(wdat)))
		else $error("counter write lost");
	a_match_flag: assert property (@(posedge clk_sys) disable iff (rst) // [R8]
		match_evt |=> cmp_flg_r)
		else $error("compare flag not set after match");
	// Check-only copy of the blocking window, so the flag outcome is watched
	logic wr_seen_r;
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			wr_seen_r <= 1'b0;
		end else if (cnt_wr) begin
			wr_seen_r <= 1'b1;
		end else if (tick) begin
			wr_seen_r <= 1'b0;
		end
	end
	a_block_after: assert property (@(posedge clk_sys) disable iff (rst) // [R13]
		wr_seen_r && tick && !cnt_wr |=> !$rose(cmp_flg_r))
		else $error("match not blocked after counter write");
	a_ctc_clear: assert property (@(posedge clk_sys) disable iff (rst) // [R21]
		(mode_r == tmr_pkg::TMR_CTC) && match_evt |=> (cnt_r == tmr_pkg::CNT_BOTTOM))
		else $error("ctc counter not cleared");
	a_normal_wrap: assert property (@(posedge clk_sys) disable iff (rst) // [R20]
		(mode_r == tmr_pkg::TMR_NORMAL) && tick && !cnt_wr && (cnt_r == 8'hff)
		|=> (cnt_r == 8'h00) && ovf_flg_r)
		else $error("normal wrap or overflow flag wrong");
	a_force_no_flag: assert property (@(posedge clk_sys) disable iff (rst) // [R12]
		force_evt && !match_evt && !cmp_flg_r |=> !cmp_flg_r)
		else $error("force strobe set compare flag");
	a_buffer_hold: assert property (@(posedge clk_sys) disable iff (rst) // [R10]
		pwm && !top_evt && $stable(mode_r) |=> $stable(ocr_r))
		else $error("compare changed off top in pwm");
	a_pin_override: assert property (@(posedge clk_sys) disable iff (rst) // [R23]
		(com_r != tmr_pkg::COM_OFF) |=> (compare_output_o == $past(wave_r)))
		else $error("pin not overridden by waveform");
endmodule : tmr_top
`default_nettype wire

// >>> dv/test_tmr_top.sv
// Directed bench for the 8-bit timer over its Wishbone registers
`timescale 1ns/10ps
`default_nettype none
module test_tmr_top;
	logic                 clk_sys;
	logic                 rst;
	tmr_pkg::tmr_wb_req_t wb_req;
	tmr_pkg::tmr_wb_rsp_t wb_rsp;
	logic                 crystal_pin_in;
	logic                 irq_ack_ovf;
	logic                 irq_ack_cmp;
	logic                 irq_ovf;
	logic                 irq_cmp;
	logic                 cmp_o;
	logic                 cmp_oe;
	logic                 pin_lvl;
	int                   rise_cnt;
	logic [31:0]          rd_v;
	logic [31:0]          prev_v;
	int                   err_total;
	int                   checks_done;
	int                   i;
	int                   hits;
	int                   rise0;

	tmr_top dut_u (
		.clk_sys          (clk_sys),
		.rst              (rst),
		.wb_req           (wb_req),
		.wb_rsp           (wb_rsp),
		.crystal_pin_in   (crystal_pin_in),
		.irq_ack_ovf      (irq_ack_ovf),
		.irq_ack_cmp      (irq_ack_cmp),
		.irq_ovf          (irq_ovf),
		.irq_cmp          (irq_cmp),
		.compare_output_o (cmp_o),
		.compare_output_oe(cmp_oe)
	);

	tmr_pin_model pin_u (
		.pin_o   (cmp_o),
		.pin_oe  (cmp_oe),
		.pin_lvl (pin_lvl),
		.rise_cnt(rise_cnt)
	);

	// 100 MHz system clock
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	task results;
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : results

	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task chk_pin(input logic got, input logic exp);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: pin got %h expected %h", $time, got, exp);
		end
	endtask : chk_pin

	// Classic single cycle; request held until ack is sampled at a rising edge
	task bus(input logic we, input logic [4:0] adr, input logic [31:0] dat);
		int n;
		@(posedge clk_sys);
		wb_req <= '{1'b1, 1'b1, we, 4'hf, adr, dat};
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (wb_rsp.ack !== 1'b1 && n < 20);
		rd_v = wb_rsp.dat;
		wb_req <= '0;
		if (wb_rsp.ack !== 1'b1) begin
			chk({31'h0, wb_rsp.ack}, 32'h1);
			results();
		end
	endtask : bus

	task wr(input logic [4:0] adr, input logic [31:0] dat);
		bus(1'b1, adr, dat);
	endtask : wr

	task rd(input logic [4:0] adr);
		bus(1'b0, adr, 32'h0);
	endtask : rd

	// Read until any bit of msk shows; running out of tries ends the run
	task poll(input logic [4:0] adr, input logic [31:0] msk);
		int n;
		n = 0;
		do begin
			rd(adr);
			n++;
		end while ((rd_v & msk) == 32'h0 && n < 400);
		if ((rd_v & msk) == 32'h0) begin
			chk(rd_v & msk, msk);
			results();
		end
	endtask : poll

	// Main sequence
	initial begin
		rst = 1'b1;
		wb_req = '0;
		crystal_pin_in = 1'b0;
		irq_ack_ovf = 1'b0;
		irq_ack_cmp = 1'b0;
		err_total = 0;
		checks_done = 0;
		repeat (10) @(posedge clk_sys);
		rst <= 1'b0;
		// Reset values, unmapped place, stopped counter access
		for (i = 0; i < 8; i++) begin
			rd(5'(4 * i));
			chk(rd_v, 32'h0);
		end
		rd(5'h03);
		chk(rd_v, 32'h0);
		wr(tmr_pkg::OFS_COUNT, 32'h1a5);
		repeat (20) @(posedge clk_sys);
		rd(tmr_pkg::OFS_COUNT);
		chk(rd_v, 32'ha5);
		wr(tmr_pkg::OFS_CMP, 32'h5a);
		rd(tmr_pkg::OFS_CMP);
		chk(rd_v, 32'h5a);
		$display("test access done");
		// Normal mode wrap, overflow flag, interrupt and its acknowledge
		wr(tmr_pkg::OFS_COUNT, 32'hf0);
		wr(tmr_pkg::OFS_MASK, 32'h1);
		wr(tmr_pkg::OFS_CTRL_B, 32'h1);
		poll(tmr_pkg::OFS_FLAG, 32'h1);
		rd(tmr_pkg::OFS_COUNT);
		chk({31'h0, rd_v[7:0] < 8'h10}, 32'h1);
		chk_pin(irq_ovf, 1'b1);
		irq_ack_ovf <= 1'b1;
		@(posedge clk_sys);
		irq_ack_ovf <= 1'b0;
		rd(tmr_pkg::OFS_FLAG);
		chk(rd_v & 32'h1, 32'h0);
		wr(tmr_pkg::OFS_MASK, 32'h0);
		poll(tmr_pkg::OFS_FLAG, 32'h2);
		chk_pin(irq_cmp, 1'b0);
		wr(tmr_pkg::OFS_MASK, 32'h2);
		repeat (2) @(posedge clk_sys);
		chk_pin(irq_cmp, 1'b1);
		irq_ack_cmp <= 1'b1;
		@(posedge clk_sys);
		irq_ack_cmp <= 1'b0;
		rd(tmr_pkg::OFS_FLAG);
		chk(rd_v & 32'h2, 32'h0);
		wr(tmr_pkg::OFS_CTRL_B, 32'h0);
		$display("test normal done");
		// Counter written equal to compare: first match is swallowed
		wr(tmr_pkg::OFS_CMP, 32'h40);
		wr(tmr_pkg::OFS_COUNT, 32'h40);
		wr(tmr_pkg::OFS_FLAG, 32'h3);
		wr(tmr_pkg::OFS_CTRL_B, 32'h1);
		rd(tmr_pkg::OFS_FLAG);
		chk(rd_v & 32'h2, 32'h0);
		wr(tmr_pkg::OFS_CTRL_B, 32'h0);
		wr(tmr_pkg::OFS_COUNT, 32'h3e);
		wr(tmr_pkg::OFS_CTRL_B, 32'h1);
		poll(tmr_pkg::OFS_FLAG, 32'h2);
		wr(tmr_pkg::OFS_CTRL_B, 32'h0);
		$display("test blocking done");
		// Clear on match keeps the count at or below the compare value
		wr(tmr_pkg::OFS_COUNT, 32'h0);
		wr(tmr_pkg::OFS_CMP, 32'h06);
		wr(tmr_pkg::OFS_CTRL_A, 32'h2);
		wr(tmr_pkg::OFS_FLAG, 32'h3);
		wr(tmr_pkg::OFS_CTRL_B, 32'h1);
		hits = 0;
		for (i = 0; i < 40; i++) begin
			rd(tmr_pkg::OFS_COUNT);
			if (rd_v > 32'h06)
				hits++;
		end
		chk(32'(hits), 32'h0);
		rd(tmr_pkg::OFS_FLAG);
		chk(rd_v & 32'h1, 32'h0);
		wr(tmr_pkg::OFS_CTRL_B, 32'h0);
		$display("test clear on match done");
		// Phase-correct: a short step downwards must appear
		wr(tmr_pkg::OFS_CTRL_A, 32'h1);
		wr(tmr_pkg::OFS_COUNT, 32'h0);
		wr(tmr_pkg::OFS_CTRL_B, 32'h1);
		hits = 0;
		prev_v = 32'h0;
		for (i = 0; i < 300 && hits == 0; i++) begin
			rd(tmr_pkg::OFS_COUNT);
			if (rd_v < prev_v && prev_v - rd_v < 32'h10)
				hits = 1;
			prev_v = rd_v;
		end
		chk(32'(hits), 32'h1);
		poll(tmr_pkg::OFS_FLAG, 32'h1);
		wr(tmr_pkg::OFS_CTRL_B, 32'h0);
		$display("test phase correct done");
		// Forced compare, output state across modes, output mode override
		wr(tmr_pkg::OFS_CTRL_A, 32'h0);
		wr(tmr_pkg::OFS_FLAG, 32'h3);
		wr(tmr_pkg::OFS_CTRL_A, 32'h90);
		wr(tmr_pkg::OFS_PORT, 32'h2);
		repeat (2) @(posedge clk_sys);
		chk_pin(pin_lvl, 1'b1);
		rd(tmr_pkg::OFS_FLAG);
		chk(rd_v, 32'h0);
		wr(tmr_pkg::OFS_CTRL_A, 32'h12);
		repeat (2) @(posedge clk_sys);
		chk_pin(pin_lvl, 1'b1);
		wr(tmr_pkg::OFS_CTRL_A, 32'h02);
		repeat (2) @(posedge clk_sys);
		chk_pin(pin_lvl, 1'b0);
		wr(tmr_pkg::OFS_PORT, 32'h3);
		wr(tmr_pkg::OFS_CTRL_A, 32'ha2);
		repeat (2) @(posedge clk_sys);
		chk_pin(pin_lvl, 1'b0);
		wr(tmr_pkg::OFS_PORT, 32'h1);
		repeat (2) @(posedge clk_sys);
		chk_pin(cmp_oe, 1'b0);
		$display("test force done");
		// Fast PWM duty from a buffered compare value
		wr(tmr_pkg::OFS_PORT, 32'h2);
		wr(tmr_pkg::OFS_COUNT, 32'h0);
		wr(tmr_pkg::OFS_CTRL_A, 32'h23);
		wr(tmr_pkg::OFS_CMP, 32'h40);
		wr(tmr_pkg::OFS_CTRL_B, 32'h1);
		repeat (300) @(posedge clk_sys);
		hits = 0;
		rise0 = rise_cnt;
		for (i = 0; i < 512; i++) begin
			@(posedge clk_sys);
			if (pin_lvl === 1'b1)
				hits++;
		end
		chk({31'h0, hits >= 120 && hits <= 140}, 32'h1);
		chk(32'(rise_cnt - rise0), 32'h2);
		wr(tmr_pkg::OFS_CMP, 32'hc0);
		rd(tmr_pkg::OFS_CMP);
		chk(rd_v, 32'hc0);
		wr(tmr_pkg::OFS_CTRL_B, 32'h0);
		$display("test fast pwm done");
		// Crystal source: only crystal rising edges advance the count
		wr(tmr_pkg::OFS_CTRL_A, 32'h0);
		wr(tmr_pkg::OFS_COUNT, 32'h0);
		wr(tmr_pkg::OFS_ASYNC, 32'h1);
		wr(tmr_pkg::OFS_CTRL_B, 32'h1);
		repeat (20) @(posedge clk_sys);
		rd(tmr_pkg::OFS_COUNT);
		chk(rd_v, 32'h0);
		for (i = 0; i < 5; i++) begin
			crystal_pin_in <= 1'b1;
			repeat (8) @(posedge clk_sys);
			crystal_pin_in <= 1'b0;
			repeat (8) @(posedge clk_sys);
		end
		rd(tmr_pkg::OFS_COUNT);
		chk(rd_v, 32'h5);
		$display("test crystal done");
		results();
	end
endmodule : test_tmr_top
`default_nettype wire

// >>> dv/tmr_pin_model.sv
// Board-side model of the compare output pin: driver plus pull-up
`timescale 1ns/10ps
`default_nettype none
module tmr_pin_model (
	input  wire logic pin_o,
	input  wire logic pin_oe,
	output var  logic pin_lvl,
	output var  int   rise_cnt
);
	// Released pin floats to the pull-up level, not to the last driven value
	always_comb begin
		pin_lvl = pin_oe ? pin_o : 1'b1;
	end

	// Rising edges seen by the external circuit
	initial begin
		rise_cnt = 0;
		forever begin
			@(posedge pin_lvl);
			rise_cnt++;
		end
	end
endmodule : tmr_pin_model
`default_nettype wire
